// ==== rfim_top.sv ====
// Rail fault interrupt masking: over-temperature warning live bit, undervoltage mask register,
// sticky event status with its own mask, and the active-low interrupt pin.
// Assumes fault inputs synchronous to clk and a single AHB-Lite master.
//
// Functional notes
// - Over-temperature warning live bit reads 1 while warning present, 0 after.
// - Mask bit 5 at 0 lets rail six undervoltage drive the pin; 1 blocks.
// - Mask bit 4 at 0 lets rail five undervoltage drive the pin; 1 blocks.
// - Mask bit 3 at 0 lets rail four undervoltage drive the pin; 1 blocks.
`timescale 1ns/100ps
`default_nettype none
module rfim_top
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output var  logic [31:0] hrdata,
   output var  logic        hreadyout,
   output var  logic        hresp,
   // Fault inputs and non-volatile load
   input  wire logic        otWarn,
   input  wire logic [2:0]  railUv,
   input  wire logic        nvmLoad,
   input  wire logic [7:0]  nvmMask,
   // Outputs
   output var  logic        intPinN,
   output var  logic        irq
);
   logic        wrPend_r;
   logic [7:0]  wrAddr_r;
   logic [7:0]  mask1_r;
   logic        otLive_r;
   logic [2:0]  railLive_r;
   logic [3:0]  status_r;
   logic [3:0]  irqMask_r;
   logic [3:0]  evRise;
   logic [3:0]  evNow;
   logic [3:0]  evPrev_r;
   logic [2:0]  railPass;
   logic        addrOk;
   logic        wrMask1;
   logic        wrStatus;
   logic        wrIrqMask;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign addrOk    = hsel && hready && htrans == rfim_pkg::TransNonseq && hsize == rfim_pkg::SizeWord;

   // Address phase capture for writes; data arrives in the following cycle.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wrPend_r <= 1'b0;
         wrAddr_r <= 8'h00;
      end
      else
      begin
         wrPend_r <= addrOk && hwrite;
         if (addrOk)
         begin
            wrAddr_r <= haddr[7:0];
         end
      end
   end

   assign wrMask1   = wrPend_r && wrAddr_r == rfim_pkg::AddrMask1;
   assign wrStatus  = wrPend_r && wrAddr_r == rfim_pkg::AddrStatus;
   assign wrIrqMask = wrPend_r && wrAddr_r == rfim_pkg::AddrIrqMask;

   // A bus write wins over a simultaneous non-volatile load, being the later intent of software.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         mask1_r <= rfim_pkg::Mask1Reset;
      end
      else if (wrMask1)
      begin
         mask1_r <= hwdata[7:0] & rfim_pkg::Mask1Used;
      end
      else if (nvmLoad)
      begin
         mask1_r <= nvmMask & rfim_pkg::Mask1Used;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         irqMask_r <= rfim_pkg::IrqMaskReset;
      end
      else if (wrIrqMask)
      begin
         irqMask_r <= hwdata[3:0];
      end
   end

   // Live bits follow the conditions and fall by themselves.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         otLive_r   <= 1'b0;
         railLive_r <= 3'h0;
      end
      else
      begin
         otLive_r   <= otWarn;
         railLive_r <= railUv;
      end
   end

   // Per-rail gating: mask bit 0 passes the fault, 1 blocks it.
   genvar g;
   generate
      for (g = 0; g < rfim_pkg::RailCount; g++)
      begin : gRail
         assign railPass[g] = railLive_r[g] && !mask1_r[rfim_pkg::RailFirst + g];
      end
   endgenerate

   // Pin is registered so it never glitches on the board.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         intPinN <= 1'b1;
      end
      else
      begin
         intPinN <= !(|railPass);
      end
   end

   // Sticky events on rising edges; a new event beats a write-one clear in the same cycle.
   assign evNow = {railLive_r, otLive_r};
   assign evRise = evNow & ~evPrev_r;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         evPrev_r <= 4'h0;
         status_r <= rfim_pkg::StatusReset;
      end
      else
      begin
         evPrev_r <= evNow;
         status_r <= (status_r & ~(wrStatus ? hwdata[3:0] : 4'h0)) | evRise;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |(status_r & ~irqMask_r);
      end
   end

   // Read data registered in the address phase, presented in the data phase.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         hrdata <= 32'h0000_0000;
      end
      else if (addrOk && !hwrite)
      begin
         if (haddr[7:0] == rfim_pkg::AddrLive)
         begin
            hrdata <= {28'h000_0000, railLive_r, otLive_r};
         end
         else if (haddr[7:0] == rfim_pkg::AddrMask1)
         begin
            hrdata <= {24'h00_0000, mask1_r};
         end
         else if (haddr[7:0] == rfim_pkg::AddrStatus)
         begin
            hrdata <= {28'h000_0000, status_r};
         end
         else if (haddr[7:0] == rfim_pkg::AddrIrqMask)
         begin
            hrdata <= {28'h000_0000, irqMask_r};
         end
         else
         begin
            hrdata <= 32'h0000_0000;
         end
      end
   end
endmodule : rfim_top
`default_nettype wire

// ==== rfim_pkg.sv ====
// Package for the rail fault interrupt masking block: register map, fields, reset values.
// Assumes a 32-bit AHB-Lite register bus and a single clock.
package rfim_pkg;
   // Register byte addresses.
   localparam logic [7:0] AddrLive    = 8'h00;
   localparam logic [7:0] AddrMask1   = 8'h04;
   localparam logic [7:0] AddrStatus  = 8'h08;
   localparam logic [7:0] AddrIrqMask = 8'h0C;
   localparam logic [7:0] AddrLoad    = 8'h10;
   // Mask register fields.
   localparam int Rail4Bit  = 3;
   localparam int Rail5Bit  = 4;
   localparam int Rail6Bit  = 5;
   localparam int MaskWidth = 6;
   localparam int RailFirst = 3;
   localparam int RailCount = 3;
   localparam logic [7:0] Mask1Reset   = 8'h00;
   localparam logic [7:0] Mask1Used    = 8'h3F;
   // Live register field.
   localparam int OtWarnBit = 0;
   // Sticky status layout: bit 0 over-temperature warning rise, bits 1..3 rail 4..6 undervoltage rise.
   localparam int EventCount = 4;
   localparam logic [3:0] StatusReset  = 4'h0;
   localparam logic [3:0] IrqMaskReset = 4'h0;
   // Transfer type and size codes.
   localparam logic [1:0] TransNonseq = 2'h2;
   localparam logic [2:0] SizeWord    = 3'h2;
endpackage : rfim_pkg

// ==== rfim_checker.sv ====
// Checker for the interrupt pin and bus response of rfim_top.
// Assumes it is bound to every rfim_top instance.
`timescale 1ns/100ps
`default_nettype none
module rfim_checker
(
   // Observed pins
   input wire logic       clk,
   input wire logic       rst,
   input wire logic [2:0] railUv,
   input wire logic       intPinN,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence sUvQuiet;
      railUv == 3'h0 ##1 railUv == 3'h0;
   endsequence
   // The pin falls two edges after a fault, so the cause must have stood two cycles earlier.
   sequence sPinFall;
      $fell(intPinN);
   endsequence
   AST_PIN_RELEASED: assert property (sUvQuiet |=> intPinN) else $error("Pin low without fault.");
   AST_PIN_FELL_CAUSE: assert property (sPinFall |-> $past(railUv, 2) != 3'h0) else $error("Pin fell uncaused.");
   AST_RDATA_UPPER: assert property (hrdata[31:8] == 24'h00_0000) else $error("Read data upper bits set.");
   AST_PIN_CAUSED: assert property (!intPinN |-> $past(railUv, 2) != 3'h0) else $error("Pin low early.");
   AST_BUS_OKAY: assert property (!hresp && hreadyout) else $error("Bad bus response.");
endmodule : rfim_checker
`default_nettype wire
bind rfim_top rfim_checker rfim_checker_i (.clk(clk), .rst(rst), .railUv(railUv), .intPinN(intPinN),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

// ==== rfim_host_model.sv ====
// Host model: counts assertions of the interrupt pin.
// Assumes the pin is sampled on clk.
`timescale 1ns/100ps
`default_nettype none
module rfim_host_model
(
   // Pin watch
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       intPinN,
   output var  logic [7:0] fallCount
);
   always_ff @(posedge clk or posedge rst)
      if (rst) fallCount <= 8'h00;
      else if ($fell(intPinN)) fallCount <= fallCount + 8'h01;
endmodule : rfim_host_model
`default_nettype wire

// ==== rail_fault_irq_masking_tb_top.sv ====
// Bench: random faults and masks, then the sticky interrupt path.
// Assumes a zero-wait AHB-Lite slave.
`timescale 1ns/100ps
`default_nettype none
module rail_fault_irq_masking_tb_top;
   logic        clk = 1'b0, rst = 1'b1, hwrite = 1'b0, otWarn = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, s = 32'h8047C5FA;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  railUv = 3'h0;
   logic [7:0]  fallCount;
   logic        hreadyout, hresp, intPinN, irq;
   int          miscompares = 0, n_checks = 0, cyc = 0;
   always #10 clk = ~clk;
   rfim_top rfim_top_i (.clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(rfim_pkg::SizeWord), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .otWarn(otWarn), .railUv(railUv), .nvmLoad(1'b0), .nvmMask(8'h00), .intPinN(intPinN),
      .irq(irq));
   rfim_host_model rfim_host_model_i (.clk(clk), .rst(rst), .intPinN(intPinN), .fallCount(fallCount));
   task automatic tally_and_finish();
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         miscompares++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      htrans <= rfim_pkg::TransNonseq;
      hwrite <= w;
      haddr  <= {24'h0, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      return v ^ (v << 5);
   endfunction : xs
   // The pin ignores the warning and the unused mask bits.
   function automatic logic pinExp(input logic [31:0] r);
      return !(|(r[10:8] & ~r[5:3]));
   endfunction : pinExp
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      bus(1'b0, rfim_pkg::AddrMask1, 32'h0);
      chk(q, 32'h0);
      for (int i = 0; i < 24; i++)
      begin
         s = xs(s);
         if (i < 2) s[11:0] = i ? 12'hF3F : 12'hF00;
         bus(1'b1, rfim_pkg::AddrMask1, {24'h0, s[7:0]});
         railUv <= s[10:8];
         otWarn <= s[11];
         repeat (3) @(posedge clk);
         chk(intPinN, pinExp(s));
         bus(1'b0, rfim_pkg::AddrLive, 32'h0);
         chk(q, {28'h0, s[10:8], s[11]});
      end
      railUv <= 3'h0;
      bus(1'b1, rfim_pkg::AddrIrqMask, 32'hF);
      bus(1'b1, rfim_pkg::AddrStatus, 32'hF);
      railUv <= 3'h7;
      repeat (3) @(posedge clk);
      chk(irq, 1'b0);
      bus(1'b1, rfim_pkg::AddrIrqMask, 32'h0);
      repeat (2) @(posedge clk);
      chk(irq, 1'b1);
      bus(1'b1, rfim_pkg::AddrStatus, 32'hF);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      bus(1'b0, 8'h14, 32'h0);
      chk(q, 32'h0);
      chk(fallCount != 8'h00, 1'b1);
      tally_and_finish();
   end
endmodule : rail_fault_irq_masking_tb_top
`default_nettype wire
